// File: verilog/psf_pkg.sv
// Purpose: constants and types for the potentiometer serial front end
// Assumes: ref_clk at 250 MHz; serial clock sampled as a plain input
// Notes: type code value is arbitrary, chosen for this design
// Behaviour
// - The first byte after chip select falls is taken only as an address byte.
// - The upper four address bits are compared with the built-in type code.
// - The low two address bits must equal the address-select pins to continue.
// - A device whose address differs does not execute the following instruction.
// - A non-volatile write cycle and its busy flag last at most 5 ms.
// - The wiper settles 5 to 10 us after a change or after power becomes stable.
// - While pause is asserted the serial data output is high impedance.
// - Serial input bits are sampled on each rising serial clock edge.
// - The byte after a matched address is split into opcode, register, pot.
// - Chip select rising after a data register write starts the save and busy.
package psf_pkg;
	localparam int          CLK_MHZ          = 250;
	localparam int          NV_WRITE_MS      = 5;
	localparam int          POWERUP_MS       = 1;
	localparam int          SETTLE_MIN_US    = 5;
	localparam int          SETTLE_MAX_US    = 10;
	localparam int          NV_WRITE_CYC     = NV_WRITE_MS * 1000 * CLK_MHZ;
	localparam int          POWERUP_CYC      = POWERUP_MS * 1000 * CLK_MHZ;
	// Settle inside the window: least time is used
	localparam int          SETTLE_CYC       = SETTLE_MIN_US * CLK_MHZ;
	localparam int          SETTLE_MAX_CYC   = SETTLE_MAX_US * CLK_MHZ;
	localparam logic [3:0]  TYPE_CODE_DEF    = 4'hA; // Arbitrary value
	localparam int          TYPE_MSB         = 7;
	localparam int          TYPE_LSB         = 4;
	localparam int          ADDR_MSB         = 1;
	localparam int          ADDR_LSB         = 0;
	localparam logic [3:0]  OP_WRITE_DATA    = 4'hC;
	localparam logic [3:0]  OP_WRITE_WIPER   = 4'hA;
	localparam logic [3:0]  OP_XFR_DATA      = 4'hD;
	localparam logic [3:0]  OP_GXFR_DATA     = 4'h1;
	localparam logic [3:0]  OP_XFR_WIPER     = 4'hE;
	localparam logic [3:0]  OP_GXFR_WIPER    = 4'h8;
	localparam logic [2:0]  BIT_LAST         = 3'h7;

	typedef enum logic [1:0] {
		PSF_ADDR,
		PSF_INSTR,
		PSF_PASS,
		PSF_IGNORE
	} psf_state_t;
endpackage

// File: verilog/psf_timer_if.sv
`timescale 1ns/1ps
// Purpose: start and busy pair between front end and its cycle timer
// Assumes: both ends on ref_clk
// Notes: start is a one-cycle pulse
interface psf_timer_if;
	logic        start;
	logic        busy;
	modport ctrl (output start, input busy);
	modport tmr  (input start, output busy);
endinterface // psf_timer_if

// File: verilog/psf_timer.sv
`timescale 1ns/1ps
// Purpose: busy window timer for write cycles and wiper settling
// Assumes: start ignored while busy
// Notes: length set by parameter so simulation can shorten it
module psf_timer #(
	parameter int CYCLES = 1000
) (
	// Clock and reset
	input  wire logic  ref_clk,
	input  wire logic  srst,
	// Control
	psf_timer_if.tmr   tif
);
	typedef struct packed {
		logic [31:0] cnt;
	} psf_tmr_st_t;

	psf_tmr_st_t st_reg;
	psf_tmr_st_t st_next;

	assign tif.busy = (st_reg.cnt != 32'h0);

	// Load on start, count down to idle
	always_comb begin
		st_next = st_reg;
		if (tif.start && !tif.busy) begin
			st_next.cnt = 32'(CYCLES);
		end else if (tif.busy) begin
			st_next.cnt = st_reg.cnt - 32'h1;
		end
	end

	always_ff @(posedge ref_clk) begin
		if (srst) begin
			st_reg <= '0;
		end else begin
			st_reg <= st_next;
		end
	end

	a_busy_bound: assert property (@(posedge ref_clk) disable iff (srst)
		st_reg.cnt <= 32'(CYCLES))
		else $error("busy window longer than allowed");
endmodule // psf_timer

// File: verilog/psf_front_end.sv
`timescale 1ns/1ps
// Purpose: address byte check and instruction byte split for a quad pot
// Assumes: serial pins come from another domain and are synchronised
// Notes: reset stands for power-up and loads the power-up delay count; counts are parameters
module psf_front_end #(
	parameter logic [3:0] TYPE_CODE    = psf_pkg::TYPE_CODE_DEF,
	parameter int         NV_CYC       = psf_pkg::NV_WRITE_CYC,
	parameter int         POWERUP_CYC  = psf_pkg::POWERUP_CYC,
	parameter int         SETTLE_CYC   = psf_pkg::SETTLE_CYC
) (
	// Clock and reset
	input  wire logic        ref_clk,
	input  wire logic        srst,
	// Serial link pins
	input  wire logic        cs_n,
	input  wire logic        sck,
	input  wire logic        si,
	input  wire logic        pause_n,
	input  wire logic [1:0]  addr_select_pins,
	// Serial data output, enable low while driven
	input  wire logic        so_data,
	output logic             so_out,
	output logic             so_oe_n,
	// Decoded instruction
	output logic             instr_valid,
	output logic [3:0]       opcode_field,
	output logic [1:0]       data_reg_select,
	output logic [1:0]       pot_select,
	output logic             addr_matched,
	output logic             pass_byte_valid,
	output logic [7:0]       pass_byte,
	// Status
	output logic             write_busy_flag,
	output logic             wiper_settling,
	output logic             powerup_done
);
	typedef struct packed {
		logic [1:0]             cs_s;
		logic [1:0]             sck_s;
		logic [1:0]             si_s;
		logic [1:0]             pause_s;
		logic [1:0]             a0_s;
		logic [1:0]             a1_s;
		logic                   sck_d;
		logic                   cs_d;
		psf_pkg::psf_state_t    state;
		logic [7:0]             shift;
		logic [2:0]             nbit;
		logic                   wr_seen;
		logic                   instr_valid;
		logic [7:0]             instr;
		logic                   matched;
		logic                   pb_valid;
		logic [7:0]             pb;
		logic                   so;
		logic                   oe_n;
		logic [31:0]            pu_cnt;
		logic                   nv_go;
		logic                   wp_go;
	} psf_st_t;

	psf_st_t st_reg;
	psf_st_t st_next;
	logic    sck_rise;
	logic    cs_rise;
	logic    cs_fall;
	logic    cs_act;
	logic [7:0] byte_in;

	psf_timer_if nv_if ();
	psf_timer_if wp_if ();

	assign nv_if.start = st_reg.nv_go;
	assign wp_if.start = st_reg.wp_go;

	psf_timer #(.CYCLES(NV_CYC)) u_nv (
		.ref_clk (ref_clk),
		.srst    (srst),
		.tif     (nv_if)
	);

	psf_timer #(.CYCLES(SETTLE_CYC)) u_wp (
		.ref_clk (ref_clk),
		.srst    (srst),
		.tif     (wp_if)
	);

	// Edge detection on second synchroniser stage only
	assign sck_rise = st_reg.sck_s[1] && !st_reg.sck_d;
	assign cs_act   = !st_reg.cs_s[1];
	assign cs_rise  = st_reg.cs_s[1] && !st_reg.cs_d;
	assign cs_fall  = !st_reg.cs_s[1] && st_reg.cs_d;
	assign byte_in  = {st_reg.shift[6:0], st_reg.si_s[1]};

	// Next state of the whole front end
	always_comb begin
		st_next          = st_reg;
		st_next.cs_s     = {st_reg.cs_s[0], cs_n};
		st_next.sck_s    = {st_reg.sck_s[0], sck};
		st_next.si_s     = {st_reg.si_s[0], si};
		st_next.pause_s  = {st_reg.pause_s[0], pause_n};
		st_next.a0_s     = {st_reg.a0_s[0], addr_select_pins[0]};
		st_next.a1_s     = {st_reg.a1_s[0], addr_select_pins[1]};
		st_next.sck_d    = st_reg.sck_s[1];
		st_next.cs_d     = st_reg.cs_s[1];
		st_next.instr_valid = 1'b0;
		st_next.pb_valid = 1'b0;
		st_next.nv_go    = 1'b0;
		st_next.wp_go    = 1'b0;
		if (st_reg.pu_cnt != 32'h0) begin
			st_next.pu_cnt = st_reg.pu_cnt - 32'h1;
			st_next.wp_go  = (st_reg.pu_cnt == 32'h1);
		end
		if (cs_fall || !cs_act) begin
			st_next.state   = psf_pkg::PSF_ADDR;
			st_next.nbit    = 3'h0;
			st_next.matched = 1'b0;
		end
		if (cs_rise) begin
			st_next.nv_go   = st_reg.wr_seen;
			st_next.wr_seen = 1'b0;
		end
		if (cs_act && sck_rise && st_reg.state != psf_pkg::PSF_IGNORE &&
			st_reg.pu_cnt == 32'h0) begin
			st_next.shift = byte_in;
			st_next.nbit  = st_reg.nbit + 3'h1;
			if (st_reg.nbit == psf_pkg::BIT_LAST) begin
				case (st_reg.state)
					psf_pkg::PSF_ADDR: begin
						if (byte_in[psf_pkg::TYPE_MSB:psf_pkg::TYPE_LSB]
							== TYPE_CODE &&
							byte_in[psf_pkg::ADDR_MSB:psf_pkg::ADDR_LSB] ==
							{st_reg.a1_s[1], st_reg.a0_s[1]}) begin
							st_next.state   = psf_pkg::PSF_INSTR;
							st_next.matched = 1'b1;
						end else begin
							st_next.state = psf_pkg::PSF_IGNORE;
						end
					end
					psf_pkg::PSF_INSTR: begin
						st_next.instr       = byte_in;
						st_next.instr_valid = 1'b1;
						st_next.state       = psf_pkg::PSF_PASS;
						st_next.wr_seen = (byte_in[7:4] ==
							psf_pkg::OP_WRITE_DATA) ||
							(byte_in[7:4] == psf_pkg::OP_XFR_WIPER) ||
							(byte_in[7:4] == psf_pkg::OP_GXFR_WIPER);
						st_next.wp_go = (byte_in[7:4] ==
							psf_pkg::OP_XFR_DATA) ||
							(byte_in[7:4] == psf_pkg::OP_GXFR_DATA);
					end
					psf_pkg::PSF_PASS: begin
						st_next.pb       = byte_in;
						st_next.pb_valid = 1'b1;
						if (st_reg.instr[7:4] == psf_pkg::OP_WRITE_WIPER) begin
							st_next.wp_go = 1'b1;
						end
					end
					default: begin
						st_next.state = psf_pkg::PSF_IGNORE;
					end
				endcase
			end
		end
		// output released on pause, mismatch or deselect
		st_next.oe_n = !st_reg.pause_s[1] || !cs_act ||
			st_reg.state != psf_pkg::PSF_PASS;
		st_next.so   = so_data;
	end

	always_ff @(posedge ref_clk) begin
		if (srst) begin
			st_reg        <= '0;
			st_reg.cs_s   <= 2'h3;
			st_reg.cs_d   <= 1'b1;
			st_reg.oe_n   <= 1'b1;
			st_reg.pu_cnt <= 32'(POWERUP_CYC);
		end else begin
			st_reg <= st_next;
		end
	end

	// Outputs
	assign so_out          = st_reg.so;
	assign so_oe_n         = st_reg.oe_n;
	assign instr_valid     = st_reg.instr_valid;
	assign opcode_field    = st_reg.instr[7:4];
	assign data_reg_select = st_reg.instr[3:2];
	assign pot_select      = st_reg.instr[1:0];
	assign addr_matched    = st_reg.matched;
	assign pass_byte_valid = st_reg.pb_valid;
	assign pass_byte       = st_reg.pb;
	assign write_busy_flag = nv_if.busy;
	assign wiper_settling  = wp_if.busy;
	assign powerup_done    = (st_reg.pu_cnt == 32'h0);

	a_instr_needs_match: assert property (@(posedge ref_clk) disable iff (srst)
		st_reg.instr_valid |-> st_reg.matched)
		else $error("instruction decoded without address match");
	a_pause_hiz: assert property (@(posedge ref_clk) disable iff (srst)
		!st_reg.pause_s[1] |=> so_oe_n)
		else $error("output driven during pause");
	a_ignore_hiz: assert property (@(posedge ref_clk) disable iff (srst)
		st_reg.state == psf_pkg::PSF_IGNORE |=> so_oe_n)
		else $error("output driven after mismatch");
	a_save_start: assert property (@(posedge ref_clk) disable iff (srst)
		(cs_rise && st_reg.wr_seen && !write_busy_flag) |=> ##1
		write_busy_flag)
		else $error("save did not start at deselect");
	a_type_check: assert property (@(posedge ref_clk) disable iff (srst)
		$rose(st_reg.matched) |-> st_reg.shift[7:4] == TYPE_CODE)
		else $error("match with wrong type code");
	a_addr_check: assert property (@(posedge ref_clk) disable iff (srst)
		$rose(st_reg.matched) |-> st_reg.shift[1:0] ==
		$past({st_reg.a1_s[1], st_reg.a0_s[1]}))
		else $error("match with wrong address");
	// bits move only on clock rise
	a_sample_edge: assert property (@(posedge ref_clk) disable iff (srst)
		(st_reg.nbit != $past(st_reg.nbit) && cs_act && $past(cs_act))
		|-> $past(sck_rise))
		else $error("bit taken without clock edge");
	a_frame_start: assert property (@(posedge ref_clk) disable iff (srst)
		!cs_act |=> st_reg.state == psf_pkg::PSF_ADDR)
		else $error("frame not restarted at address byte");
	a_instr_fields: assert property (@(posedge ref_clk) disable iff (srst)
		st_reg.instr_valid |-> {opcode_field, data_reg_select, pot_select}
		== st_reg.shift)
		else $error("instruction fields do not match byte");
endmodule // psf_front_end

// File: sim/psf_master_model.sv
// Purpose: serial bus master at the far side of the front end
// Assumes: driven on the falling edge of ref_clk
// Notes: sck idles low between frames; si is inverted once a bit is done
`timescale 1ns/1ps
module psf_master_model (
	// Clock
	input  wire logic ref_clk,
	// Serial pins
	output logic      cs_n,
	output logic      sck,
	output logic      si
);
	// Idle levels at time zero
	initial begin
		cs_n = 1'b1;
		sck  = 1'b0;
		si   = 1'b0;
	end

	// Wait a number of falling edges
	task automatic hold(input int n);
		repeat (n) @(negedge ref_clk);
	endtask

	task automatic select();
		cs_n = 1'b0;
		hold(8);
	endtask

	// Close the frame after the last bit
	task automatic deselect();
		hold(8);
		cs_n = 1'b1;
		hold(8);
	endtask

	// bit set before each rising sck, MSB first
	task automatic send_byte(input logic [7:0] b);
		for (int i = 7; i >= 0; i--) begin
			si = b[i];
			hold(6);
			sck = 1'b1;
			hold(8);
			sck = 1'b0;
			si  = ~b[i]; // Old bit is not held past sck fall
			hold(2);
		end
	endtask
endmodule // psf_master_model

// File: sim/psf_front_end_tb_top.sv
// Purpose: self-checking bench for the serial front end
// Assumes: shortened counts; serial clock period 64 ns
// Notes: stimulus on the falling edge of ref_clk
`timescale 1ns/1ps
module psf_front_end_tb_top;
	localparam logic [3:0] TC = psf_pkg::TYPE_CODE_DEF;
	localparam int         NV = 50;
	localparam int         PU = 20;
	localparam int         ST = 10;
	logic       ref_clk, srst, cs_n, sck, si, pause_n, so_data;
	logic [1:0] pins;
	logic       so_out, so_oe_n, instr_valid, addr_matched, pbv;
	logic [3:0] opf;
	logic [1:0] drs, pts;
	logic [7:0] pbyte;
	logic       busy, settle, pu_done;
	int         err_count, checks_done, iv_count, cyc, n0, n1, pb_count;
	int         nv_run, st_run;
	logic [3:0] ops [10] = '{4'h9, 4'hA, 4'hB, 4'hC, 4'hD,
		4'hE, 4'h1, 4'h8, 4'h2, 4'h5};

	psf_master_model u_psf_master_model (.ref_clk(ref_clk), .cs_n(cs_n),
		.sck(sck), .si(si));

	psf_front_end #(.TYPE_CODE(TC), .NV_CYC(NV), .POWERUP_CYC(PU),
		.SETTLE_CYC(ST)) u_psf_front_end (.ref_clk(ref_clk), .srst(srst),
		.cs_n(cs_n), .sck(sck), .si(si), .pause_n(pause_n),
		.addr_select_pins(pins), .so_data(so_data), .so_out(so_out),
		.so_oe_n(so_oe_n), .instr_valid(instr_valid), .opcode_field(opf),
		.data_reg_select(drs), .pot_select(pts),
		.addr_matched(addr_matched), .pass_byte_valid(pbv),
		.pass_byte(pbyte), .write_busy_flag(busy),
		.wiper_settling(settle), .powerup_done(pu_done));

	// Clock generation
	initial begin
		ref_clk = 1'b0;
		forever #2 ref_clk = ~ref_clk;
	end

	// Count pulses and the length of the running timer windows
	always @(posedge ref_clk) begin
		if (instr_valid === 1'b1) iv_count++;
		if (pbv === 1'b1) pb_count++;
		nv_run = (busy === 1'b1) ? nv_run + 1 : 0;
		st_run = (settle === 1'b1) ? st_run + 1 : 0;
	end

	task automatic end_of_test();
		if (err_count == 0 && checks_done > 0) begin
			$display("All checks passed");
		end else begin
			$display("Checks failed");
		end
		$finish;
	endtask

	task automatic chk(input logic [7:0] got, input logic [7:0] exp);
		checks_done++;
		if (got !== exp) begin
			err_count++;
			$display("unexpected at %0t: got %h exp %h", $time, got, exp);
		end
	endtask

	function automatic logic sel(input int w);
		case (w)
			0: return pu_done;
			1: return busy;
			default: return settle;
		endcase
	endfunction

	// Bounded wait for a status level; cyc holds the cycles waited
	task automatic wait_for(input int w, input logic lvl);
		cyc = 0;
		while (sel(w) !== lvl && cyc < 3000) begin
			@(negedge ref_clk);
			cyc++;
		end
		if (cyc == 3000) begin
			err_count++;
			end_of_test();
		end
	endtask

	// Whole length of the current or next high window of a status output
	task automatic measure(input int w);
		wait_for(w, 1'b1);
		wait_for(w, 1'b0);
		cyc = (w == 1) ? nv_run : st_run;
	endtask

	// Address and instruction bytes, frame left open
	task automatic frame(input logic [7:0] a, input logic [7:0] ins);
		u_psf_master_model.select();
		u_psf_master_model.send_byte(a);
		u_psf_master_model.send_byte(ins);
	endtask

	// Main sequence
	initial begin
		srst = 1'b1;
		pause_n = 1'b1;
		so_data = 1'b1;
		pins = 2'h0;
		err_count = 0;
		checks_done = 0;
		iv_count = 0;
		pb_count = 0;
		repeat (10) @(negedge ref_clk);
		srst = 1'b0;
		wait_for(0, 1'b1);
		chk(8'(cyc >= PU && cyc <= PU + 3), 8'h1);
		measure(2);
		chk(8'(cyc), 8'(ST));
		for (int k = 0; k < 10; k++) begin
			pins = k[1:0];
			n0 = iv_count;
			frame({TC, 2'b00, pins}, {ops[k], ~pins, pins});
			chk(8'(addr_matched), 8'h1);
			chk(8'(iv_count - n0), 8'h1);
			chk(8'(opf), 8'(ops[k]));
			chk(8'({drs, pts}), 8'({~pins, pins}));
			u_psf_master_model.deselect();
		end
		wait_for(1, 1'b0);
		wait_for(2, 1'b0);
		pins = 2'h1;
		n0 = iv_count;
		frame({TC, 2'b00, 2'h2}, 8'h9C);
		chk(8'(addr_matched), 8'h0);
		chk(8'(so_oe_n), 8'h1);
		u_psf_master_model.send_byte(8'h9C);
		chk(8'(iv_count - n0), 8'h0);
		u_psf_master_model.deselect();
		frame({4'h3, 2'b00, 2'h1}, 8'h9C);
		chk(8'(addr_matched), 8'h0);
		chk(8'(iv_count - n0), 8'h0);
		u_psf_master_model.deselect();
		frame({TC, 2'b00, 2'h1}, 8'hC6);
		n1 = pb_count;
		u_psf_master_model.send_byte(8'h5A);
		chk(pbyte, 8'h5A);
		chk(8'(pb_count - n1), 8'h1);
		chk(8'(so_oe_n), 8'h0);
		so_data = 1'b0;
		repeat (3) @(negedge ref_clk);
		chk(8'(so_out), 8'h0);
		pause_n = 1'b0;
		repeat (6) @(negedge ref_clk);
		chk(8'(so_oe_n), 8'h1);
		pause_n = 1'b1;
		repeat (6) @(negedge ref_clk);
		chk(8'(so_oe_n), 8'h0);
		chk(8'(busy), 8'h0);
		u_psf_master_model.deselect();
		chk(8'(so_oe_n), 8'h1);
		measure(1);
		chk(8'(cyc), 8'(NV));
		frame({TC, 2'b00, 2'h1}, 8'hA3);
		chk(8'(settle), 8'h0);
		u_psf_master_model.send_byte(8'h33);
		measure(2);
		chk(8'(cyc), 8'(ST));
		u_psf_master_model.deselect();
		end_of_test();
	end
endmodule // psf_front_end_tb_top
